// ==== dfw_defs.vh ====
// Register offsets, bit positions and limits for the drive fault and warning latches
`ifndef DFW_DEFS_VH
`define DFW_DEFS_VH
`define DFW_ADDR_W 8
`define DFW_OFF_FAULT 8'hca
`define DFW_OFF_WARN 8'hcb
`define DFW_OFF_CTRL 8'hd0
`define DFW_OFF_OVT 8'hd1
`define DFW_OFF_UVT 8'hd2
`define DFW_OFF_PLT 8'hd3
`define DFW_OFF_GIT 8'hd4
`define DFW_OFF_VRT 8'hd5
`define DFW_OFF_CFG 8'hd6
`define DFW_OFF_GAIN 8'hd7
`define DFW_OFF_LIMIT 8'hd8
`define DFW_CTRL_FLT_RST 6
`define DFW_CTRL_WRN_RST 9
`define DFW_CFG_TEST_MODE 0
`define DFW_CFG_PARALLEL 1
`define DFW_CFG_HIGH_POWER 2
`define DFW_REF_MAX 16'h0fff
`define DFW_OVT_MAX_MP 16'h0384
`define DFW_OVT_MAX_HP 16'h039d
`define DFW_ALIGN_MAX_DEG 16'h0005
`define DFW_GAIN_MAX 16'h7fff
`define DFW_TEST_CODE_MAX 16'h000f
`define DFW_LINK_ERR_LIMIT 2'd2
`endif

// ==== dfw_latches.v ====
// Drive fault and warning status latches with register port
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
`include "dfw_defs.vh"
// Contract
// - Fault-level thermal switch open sets fault bit 7; in parallel mode also module status bit 12.
// - Missing sine or cosine sensor signal sets fault bit 8.
// - Blown sensor module fuse sets fault bit 9.
// - Speed above over-speed trip value sets fault bit 10.
// - Power technology module, interface or cable problem sets fault bit 11.
// - Rack bus modules not answering sets fault bit 13.
// - Controller task stopping while minor loop runs sets fault bit 14.
// - Two consecutive link errors after link established set fault bit 15.
// - Warning bits hold until control word bit 9 is set.
// - Warning bits cause no action by themselves.
// - Bus above over-voltage threshold sets warning 0, limits torque, sets warning 4 (the code sets warning 4 in run mode only, not in test mode).
// - Bus below under-voltage threshold sets warning 1, limits torque, sets warning 4 (the code sets warning 4 in run mode only, not in test mode).
// - Ground current above its threshold sets warning bit 2.
// - Bus ripple above ripple threshold sets warning bit 3.
// - Run mode: reference beyond 4095 or voltage limiting sets warning bit 4.
// - Test mode: illegal bridge test code sets warning bit 4.
// - Current sharing failure sets warning 6 and module phase bit 13-15.
// - Warning-level thermal switch open sets warning 7; in parallel mode also module bit 12.
// - Out-of-limit gain write sets warning 8; old value is kept.
// - Threshold order or over-voltage maximum violated sets warning bit 8.
// - Parallel mode: alignment phase error above 5 degrees sets warning 10.
// - No rack airflow sets warning bit 12.
// - Fault bits hold until control bit 6; persisting faults set again.
// - Any set fault bit turns the drive off.
module dfw_latches (
   input wire clk_sys,
   input wire srst,
   input wire ce,
   input wire [7:0] reg_addr,
   input wire [15:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [15:0] reg_rdata,
   input wire fault_overtemp,
   input wire fault_sensor_wire_broken,
   input wire fault_sensor_fuse,
   input wire [15:0] motor_speed,
   input wire [15:0] overspeed_trip,
   input wire fault_power_tech_module,
   input wire fault_rack_bus,
   input wire task_running,
   input wire minor_loop_running,
   input wire link_msg_strobe,
   input wire link_msg_error,
   input wire [15:0] bus_voltage,
   input wire [15:0] ground_current,
   input wire [15:0] bus_ripple,
   input wire [15:0] regulator_ref,
   input wire [15:0] bridge_test_code,
   input wire warn_overtemp,
   input wire [2:0] share_fail_phase,
   input wire align_done,
   input wire [15:0] align_phase_err,
   input wire airflow_ok,
   output reg [15:0] drive_fault_latch,
   output reg [15:0] drive_warning_latch,
   output reg [15:0] module_status,
   output reg drive_off,
   output reg torque_limit,
   output reg [15:0] position_sensor_gain
);
   reg [15:0] ctrl_reg;
   reg [15:0] overvoltage_threshold;
   reg [15:0] undervoltage_threshold;
   reg [15:0] power_loss_threshold;
   reg [15:0] ground_current_threshold;
   reg [15:0] ripple_threshold;
   reg [2:0] cfg_reg;
   reg link_up_reg;
   reg [1:0] link_err_cnt_reg;
   reg bad_gain_reg;
   reg [15:0] fault_next;
   reg [15:0] warn_next;
   reg [15:0] mod_next;
   reg [1:0] link_err_next;
   reg [15:0] ref_mag;
   reg ov;
   reg uv;
   reg thr_bad;

   // Register select codes from the address decoder
   localparam [3:0] SEL_NONE = 4'h0;
   localparam [3:0] SEL_FAULT = 4'h1;
   localparam [3:0] SEL_WARN = 4'h2;
   localparam [3:0] SEL_CTRL = 4'h3;
   localparam [3:0] SEL_OV_THR = 4'h4;
   localparam [3:0] SEL_UV_THR = 4'h5;
   localparam [3:0] SEL_PL_THR = 4'h6;
   localparam [3:0] SEL_GC_THR = 4'h7;
   localparam [3:0] SEL_RIP_THR = 4'h8;
   localparam [3:0] SEL_CFG = 4'h9;
   localparam [3:0] SEL_GAIN = 4'ha;
   localparam [3:0] SEL_STAT = 4'hb;

   // Address decoder shared by the write and read paths
   function [3:0] reg_sel;
      input [7:0] a;
      begin
         if (a == `DFW_OFF_FAULT) begin
            reg_sel = SEL_FAULT;
         end else if (a == `DFW_OFF_WARN) begin
            reg_sel = SEL_WARN;
         end else if (a == `DFW_OFF_CTRL) begin
            reg_sel = SEL_CTRL;
         end else if (a == `DFW_OFF_OVT) begin
            reg_sel = SEL_OV_THR;
         end else if (a == `DFW_OFF_UVT) begin
            reg_sel = SEL_UV_THR;
         end else if (a == `DFW_OFF_PLT) begin
            reg_sel = SEL_PL_THR;
         end else if (a == `DFW_OFF_GIT) begin
            reg_sel = SEL_GC_THR;
         end else if (a == `DFW_OFF_VRT) begin
            reg_sel = SEL_RIP_THR;
         end else if (a == `DFW_OFF_CFG) begin
            reg_sel = SEL_CFG;
         end else if (a == `DFW_OFF_GAIN) begin
            reg_sel = SEL_GAIN;
         end else if (a == `DFW_OFF_LIMIT) begin
            reg_sel = SEL_STAT;
         end else begin
            reg_sel = SEL_NONE;
         end
      end
   endfunction

   // Unsigned magnitude of a two's complement word
   function [15:0] abs16;
      input [15:0] v;
      begin
         abs16 = v[15] ? (~v + 16'h0001) : v;
      end
   endfunction

   wire flt_rst = ctrl_reg[`DFW_CTRL_FLT_RST];
   wire wrn_rst = ctrl_reg[`DFW_CTRL_WRN_RST];
   wire test_mode = cfg_reg[`DFW_CFG_TEST_MODE];
   wire gain_ok = (reg_wdata <= `DFW_GAIN_MAX);
   wire [3:0] bus_sel = reg_sel(reg_addr);

   always @* begin
      ov = (bus_voltage > overvoltage_threshold);
      uv = (bus_voltage < undervoltage_threshold);
      ref_mag = abs16(regulator_ref);
      thr_bad = !((power_loss_threshold < undervoltage_threshold) &&
                  (undervoltage_threshold < overvoltage_threshold)) ||
                (overvoltage_threshold > (cfg_reg[`DFW_CFG_HIGH_POWER] ?
                 `DFW_OVT_MAX_HP : `DFW_OVT_MAX_MP));
      link_err_next = link_err_cnt_reg;
      if (link_msg_strobe) begin
         if (!link_msg_error) begin
            link_err_next = 2'd0;
         end else if (link_err_cnt_reg != `DFW_LINK_ERR_LIMIT) begin
            link_err_next = link_err_cnt_reg + 2'd1;
         end
      end
      // reset clears, then conditions set again at once
      fault_next = flt_rst ? 16'h0000 : drive_fault_latch;
      mod_next = (flt_rst || wrn_rst) ? 16'h0000 : module_status;
      if (fault_overtemp) begin
         fault_next[7] = 1'b1;
         if (cfg_reg[`DFW_CFG_PARALLEL]) begin
            mod_next[12] = 1'b1;
         end
      end
      if (fault_sensor_wire_broken) begin
         fault_next[8] = 1'b1;
      end
      if (fault_sensor_fuse) begin
         fault_next[9] = 1'b1;
      end
      if (abs16(motor_speed) > overspeed_trip) begin
         fault_next[10] = 1'b1;
      end
      if (fault_power_tech_module) begin
         fault_next[11] = 1'b1;
      end
      if (fault_rack_bus) begin
         fault_next[13] = 1'b1;
      end
      if (!task_running && minor_loop_running) begin
         fault_next[14] = 1'b1;
      end
      if (link_up_reg && link_err_next == `DFW_LINK_ERR_LIMIT) begin
         fault_next[15] = 1'b1;
      end
      warn_next = wrn_rst ? 16'h0000 : drive_warning_latch;
      if (ov) begin
         warn_next[0] = 1'b1;
      end
      if (uv) begin
         warn_next[1] = 1'b1;
      end
      if (ground_current > ground_current_threshold) begin
         warn_next[2] = 1'b1;
      end
      if (bus_ripple > ripple_threshold) begin
         warn_next[3] = 1'b1;
      end
      if (test_mode) begin
         if (bridge_test_code > `DFW_TEST_CODE_MAX) begin
            warn_next[4] = 1'b1;
         end
      end else begin
         if (ref_mag > `DFW_REF_MAX || ov || uv) begin
            warn_next[4] = 1'b1;
         end
      end
      if (share_fail_phase != 3'b000) begin
         warn_next[6] = 1'b1;
         mod_next[15:13] = mod_next[15:13] | share_fail_phase;
      end
      if (warn_overtemp) begin
         warn_next[7] = 1'b1;
         if (cfg_reg[`DFW_CFG_PARALLEL]) begin
            mod_next[12] = 1'b1;
         end
      end
      if (bad_gain_reg || thr_bad) begin
         warn_next[8] = 1'b1;
      end
      if (cfg_reg[`DFW_CFG_PARALLEL] && align_done &&
          align_phase_err > `DFW_ALIGN_MAX_DEG) begin
         warn_next[10] = 1'b1;
      end
      if (!airflow_ok) begin
         warn_next[12] = 1'b1;
      end
   end

   always @(posedge clk_sys) begin
      if (srst) begin
         ctrl_reg <= 16'h0000;
         overvoltage_threshold <= 16'h0000;
         undervoltage_threshold <= 16'h0000;
         power_loss_threshold <= 16'h0000;
         ground_current_threshold <= 16'h0000;
         ripple_threshold <= 16'h0000;
         cfg_reg <= 3'b000;
         position_sensor_gain <= 16'h0000;
         bad_gain_reg <= 1'b0;
         link_up_reg <= 1'b0;
         link_err_cnt_reg <= 2'd0;
         drive_fault_latch <= 16'h0000;
         drive_warning_latch <= 16'h0000;
         module_status <= 16'h0000;
         drive_off <= 1'b0;
         torque_limit <= 1'b0;
         reg_rdata <= 16'h0000;
      end else if (ce) begin
         // Reset bits act for one cycle then self-clear
         ctrl_reg <= 16'h0000;
         bad_gain_reg <= 1'b0;
         link_err_cnt_reg <= link_err_next;
         if (link_msg_strobe && !link_msg_error) begin
            link_up_reg <= 1'b1;
         end
         // latches change only by conditions and reset bits
         drive_fault_latch <= fault_next;
         drive_warning_latch <= warn_next;
         module_status <= mod_next;
         // fault turns drive off, warnings do not
         drive_off <= |fault_next;
         // torque limiting on bus voltage warning
         torque_limit <= ov | uv;
         if (reg_wr) begin
            if (bus_sel == SEL_CTRL) begin
               ctrl_reg <= reg_wdata;
            end else if (bus_sel == SEL_OV_THR) begin
               overvoltage_threshold <= reg_wdata;
            end else if (bus_sel == SEL_UV_THR) begin
               undervoltage_threshold <= reg_wdata;
            end else if (bus_sel == SEL_PL_THR) begin
               power_loss_threshold <= reg_wdata;
            end else if (bus_sel == SEL_GC_THR) begin
               ground_current_threshold <= reg_wdata;
            end else if (bus_sel == SEL_RIP_THR) begin
               ripple_threshold <= reg_wdata;
            end else if (bus_sel == SEL_CFG) begin
               cfg_reg <= reg_wdata[2:0];
            end else if (bus_sel == SEL_GAIN) begin
               if (gain_ok) begin
                  position_sensor_gain <= reg_wdata;
               end else begin
                  bad_gain_reg <= 1'b1;
               end
            end
         end
         if (reg_rd) begin
            if (bus_sel == SEL_FAULT) begin
               reg_rdata <= drive_fault_latch;
            end else if (bus_sel == SEL_WARN) begin
               reg_rdata <= drive_warning_latch;
            end else if (bus_sel == SEL_OV_THR) begin
               reg_rdata <= overvoltage_threshold;
            end else if (bus_sel == SEL_UV_THR) begin
               reg_rdata <= undervoltage_threshold;
            end else if (bus_sel == SEL_PL_THR) begin
               reg_rdata <= power_loss_threshold;
            end else if (bus_sel == SEL_GC_THR) begin
               reg_rdata <= ground_current_threshold;
            end else if (bus_sel == SEL_RIP_THR) begin
               reg_rdata <= ripple_threshold;
            end else if (bus_sel == SEL_CFG) begin
               reg_rdata <= {13'h0, cfg_reg};
            end else if (bus_sel == SEL_GAIN) begin
               reg_rdata <= position_sensor_gain;
            end else if (bus_sel == SEL_STAT) begin
               reg_rdata <= module_status;
            end else begin
               reg_rdata <= 16'h0000;
            end
         end
      end
   end
endmodule

// ==== dfw_properties.sv ====
// Port assertions for the drive fault and warning latches
`timescale 1ns/1ps
`include "dfw_defs.vh"
module dfw_latch_checker (
   input wire clk_sys,
   input wire srst,
   input wire ce,
   input wire [7:0] reg_addr,
   input wire reg_wr,
   input wire reg_rd,
   input wire [15:0] reg_rdata,
   input wire fault_overtemp,
   input wire task_running,
   input wire minor_loop_running,
   input wire warn_overtemp,
   input wire airflow_ok,
   input wire [15:0] drive_fault_latch,
   input wire [15:0] drive_warning_latch,
   input wire drive_off
);
   wire ctl_wr = reg_wr && reg_addr == `DFW_OFF_CTRL;
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (srst);
   AST_FLT_OVERTEMP:
      assert property (ce && fault_overtemp |=> drive_fault_latch[7])
      else $error("overtemp fault not latched");
   AST_FLT_TASK:
      assert property (ce && minor_loop_running && !task_running |=> drive_fault_latch[14])
      else $error("task stop fault not latched");
   AST_WRN_OVERTEMP:
      assert property (ce && warn_overtemp |=> drive_warning_latch[7])
      else $error("overtemp warning not latched");
   AST_WARN_FAN_LOSS:
      assert property (ce && !airflow_ok |=> drive_warning_latch[12])
      else $error("fan loss warning not latched");
   AST_DRIVE_OFF:
      assert property (drive_fault_latch != 16'h0000 |-> drive_off)
      else $error("drive left on with a fault set");
   AST_FLT_HOLD:
      assert property ($past(ce) && !$past(ctl_wr)
         |=> (drive_fault_latch & $past(drive_fault_latch)) == $past(drive_fault_latch))
      else $error("fault bit dropped without reset");
   AST_WRN_HOLD:
      assert property ($past(ce) && !$past(ctl_wr)
         |=> (drive_warning_latch & $past(drive_warning_latch)) == $past(drive_warning_latch))
      else $error("warning bit dropped without reset");
   AST_READ_FAULT:
      assert property (ce && reg_rd && reg_addr == `DFW_OFF_FAULT
         |=> reg_rdata == $past(drive_fault_latch))
      else $error("fault word read back wrong");
   cover property (ctl_wr && drive_fault_latch != 16'h0000);
   cover property (ctl_wr && drive_warning_latch[0]);
   cover property (drive_fault_latch[15]);
endmodule
bind dfw_latches dfw_latch_checker chk (.*);

// ==== dfw_host_model.sv ====
// Drive controller model: register master of the latch block
`timescale 1ns/1ps
module dfw_host_model (
   input wire clk_sys,
   output reg [7:0] reg_addr = 8'h00,
   output reg [15:0] reg_wdata = 16'h0000,
   output reg reg_wr = 1'b0,
   output reg reg_rd = 1'b0,
   input wire [15:0] reg_rdata
);
   task wr(input [7:0] a, input [15:0] v);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask
   task rd(input [7:0] a, output [15:0] v);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      @(posedge clk_sys);
      v = reg_rdata;
   endtask
endmodule

// ==== testbench.sv ====
// Self-checking bench for the drive fault and warning latches
`timescale 1ns/1ps
`include "dfw_defs.vh"
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin mismatches++; \
   $display("BAD t=%0t got %h exp %h", $time, a, e); end end
module testbench;
   reg clk_sys = 0, srst = 1, ce = 1, task_running = 1, minor_loop_running = 0;
   reg link_msg_strobe = 0, link_msg_error = 0, warn_overtemp = 0, align_done = 0;
   reg airflow_ok = 1;
   reg [4:0] fin = 0;
   reg [2:0] share_fail_phase = 0;
   reg [15:0] motor_speed = 0, overspeed_trip = 16'h0100, bus_voltage = 16'h0280;
   reg [15:0] ground_current = 0, bus_ripple = 0, regulator_ref = 0, bridge_test_code = 0;
   reg [15:0] align_phase_err = 0, d;
   wire [7:0] reg_addr;
   wire [15:0] reg_wdata, reg_rdata, drive_fault_latch, drive_warning_latch, module_status;
   wire [15:0] position_sensor_gain;
   wire reg_wr, reg_rd, drive_off, torque_limit;
   integer mismatches = 0, checked = 0, i;
   localparam [79:0] FM = {16'h2000, 16'h0800, 16'h0200, 16'h0100, 16'h0080};
   localparam [223:0] WE = {16'h0000, 16'h0010, 16'h0000, 16'h0400, 16'h1000, 16'h0080,
      16'h0040, 16'h0010, 16'h0000, 16'h0010, 16'h0008, 16'h0004, 16'h0012, 16'h0011};
   always #20 clk_sys = ~clk_sys;
   dfw_latches uut (.*, .fault_overtemp(fin[0]), .fault_sensor_wire_broken(fin[1]),
      .fault_sensor_fuse(fin[2]), .fault_power_tech_module(fin[3]), .fault_rack_bus(fin[4]));
   dfw_host_model host (.*);
   task complete_run;
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task rdchk(input [7:0] a, input [15:0] e);
      host.rd(a, d);
      `CHK(d, e)
   endtask
   task fclr;
      host.wr(`DFW_OFF_CTRL, 16'h0040);
   endtask
   task wclr;
      host.wr(`DFW_OFF_CTRL, 16'h0200);
   endtask
   task lnk(input e);
      @(posedge clk_sys);
      link_msg_strobe <= 1'b1;
      link_msg_error <= e;
      @(posedge clk_sys);
      link_msg_strobe <= 1'b0;
   endtask
   task wcase(input integer k, input [15:0] e);
      host.wr(`DFW_OFF_CFG, k > 11 ? 16'h0001 : (k > 9 || k == 8) ? 16'h0002 : 16'h0000);
      @(posedge clk_sys);
      case (k)
         0: bus_voltage <= 16'h0350;
         1: bus_voltage <= 16'h0150;
         2: ground_current <= 16'h0060;
         3: bus_ripple <= 16'h0050;
         4: regulator_ref <= 16'h1000;
         5: regulator_ref <= 16'h0fff;
         6: regulator_ref <= 16'hf000;
         7: share_fail_phase <= 3'h2;
         8: warn_overtemp <= 1'b1;
         9: airflow_ok <= 1'b0;
         10, 11: begin
            align_done <= 1'b1;
            align_phase_err <= k == 10 ? 16'h0006 : 16'h0005;
         end
         default: bridge_test_code <= k == 12 ? 16'h0010 : 16'h000f;
      endcase
      repeat (2) @(posedge clk_sys);
      rdchk(`DFW_OFF_WARN, e);
      `CHK(drive_off, 1'b0)
      `CHK(torque_limit, k < 2)
      if (k == 7 || k == 8) `CHK(module_status, k == 7 ? 16'h4000 : 16'h1000)
      @(posedge clk_sys);
      bus_voltage <= 16'h0280;
      ground_current <= 16'h0000;
      bus_ripple <= 16'h0000;
      regulator_ref <= 16'h0000;
      share_fail_phase <= 3'h0;
      warn_overtemp <= 1'b0;
      airflow_ok <= 1'b1;
      align_done <= 1'b0;
      bridge_test_code <= 16'h0000;
      rdchk(`DFW_OFF_WARN, e);
      wclr;
      rdchk(`DFW_OFF_WARN, 16'h0000);
      $display("warning test %0d done", k);
   endtask
   initial begin
      repeat (20000) @(posedge clk_sys);
      mismatches++;
      complete_run;
   end
   initial begin
      repeat (6) @(posedge clk_sys);
      srst <= 1'b0;
      host.wr(`DFW_OFF_OVT, 16'h0300);
      host.wr(`DFW_OFF_UVT, 16'h0200);
      host.wr(`DFW_OFF_PLT, 16'h0100);
      host.wr(`DFW_OFF_GIT, 16'h0050);
      host.wr(`DFW_OFF_VRT, 16'h0040);
      host.wr(`DFW_OFF_FAULT, 16'hffff);
      wclr;
      rdchk(`DFW_OFF_WARN, 16'h0000);
      rdchk(`DFW_OFF_FAULT, 16'h0000);
      rdchk(8'h10, 16'h0000);
      rdchk(`DFW_OFF_OVT, 16'h0300);
      for (i = 0; i < 5; i++) begin
         @(posedge clk_sys);
         fin <= 5'h01 << i;
         rdchk(`DFW_OFF_FAULT, FM[i*16 +: 16]);
         `CHK(drive_off, 1'b1)
         fclr;
         rdchk(`DFW_OFF_FAULT, FM[i*16 +: 16]);
         @(posedge clk_sys);
         fin <= 5'h00;
         rdchk(`DFW_OFF_FAULT, FM[i*16 +: 16]);
         fclr;
         rdchk(`DFW_OFF_FAULT, 16'h0000);
         $display("fault test %0d done", i);
      end
      host.wr(`DFW_OFF_CFG, 16'h0002);
      @(posedge clk_sys);
      ce <= 1'b0;
      fin <= 5'h01;
      repeat (3) @(posedge clk_sys);
      `CHK(drive_fault_latch, 16'h0000)
      ce <= 1'b1;
      repeat (2) @(posedge clk_sys);
      `CHK(drive_fault_latch, 16'h0080)
      `CHK(module_status, 16'h1000)
      fin <= 5'h00;
      fclr;
      rdchk(`DFW_OFF_FAULT, 16'h0000);
      $display("clock enable test done");
      @(posedge clk_sys);
      motor_speed <= 16'hfe00;
      minor_loop_running <= 1'b1;
      task_running <= 1'b0;
      rdchk(`DFW_OFF_FAULT, 16'h4400);
      @(posedge clk_sys);
      motor_speed <= 16'h0100;
      task_running <= 1'b1;
      fclr;
      rdchk(`DFW_OFF_FAULT, 16'h0000);
      lnk(1'b1);
      lnk(1'b1);
      rdchk(`DFW_OFF_FAULT, 16'h0000);
      for (i = 0; i < 4; i++) lnk(i[0]);
      rdchk(`DFW_OFF_FAULT, 16'h0000);
      lnk(1'b1);
      rdchk(`DFW_OFF_FAULT, 16'h8000);
      lnk(1'b0);
      fclr;
      rdchk(`DFW_OFF_FAULT, 16'h0000);
      $display("speed task link test done");
      for (i = 0; i < 14; i++) wcase(i, WE[i*16 +: 16]);
      host.wr(`DFW_OFF_GAIN, 16'h1234);
      host.wr(`DFW_OFF_GAIN, 16'h8000);
      repeat (2) @(posedge clk_sys);
      rdchk(`DFW_OFF_WARN, 16'h0100);
      `CHK(position_sensor_gain, 16'h1234)
      rdchk(`DFW_OFF_GAIN, 16'h1234);
      host.wr(`DFW_OFF_CFG, 16'h0000);
      host.wr(`DFW_OFF_OVT, 16'h0385);
      wclr;
      rdchk(`DFW_OFF_WARN, 16'h0100);
      host.wr(`DFW_OFF_CFG, 16'h0004);
      wclr;
      rdchk(`DFW_OFF_WARN, 16'h0000);
      rdchk(`DFW_OFF_CFG, 16'h0004);
      $display("gain threshold test done");
      complete_run;
   end
endmodule
